// ==== common/trip_regs.vh ====
`ifndef TRIP_REGS_VH
`define TRIP_REGS_VH

// register byte offsets
`define REG_CTRL          8'h00
`define REG_CMD           8'h04
`define REG_STATUS        8'h08
`define REG_LOG_PTR       8'h0C
`define REG_LOG_BASE      8'h20
`define LOG_DEPTH         8
`define LOG_PTR_W         3

// control register fields
`define CTRL_RATING_LSB   0
`define CTRL_SBT_LSB      2
`define CTRL_PLD_BIT      4
`define CTRL_LVS_BIT      5
`define CTRL_PAR_BIT      6
`define CTRL_RESET        32'h0000_0000

// command register fields
`define CMD_RESET_BIT     0
`define CMD_DEFAULTS_BIT  1

// status register fields
`define ST_CODE_LSB       0
`define ST_TRIPPED_BIT    8
`define ST_FATAL_BIT      9
`define ST_STOPPING_BIT   10
`define ST_BRAKE_BIT      11
`define ST_UV_BIT         12
`define ST_HF_BIT         13
`define ST_MOD_LSB        16
`define ST_DEFLT_BIT      20
`define ST_RSTOK_BIT      21

// trip codes
`define TC_NONE           8'h00
`define TC_UV             8'h01
`define TC_OV             8'h02
`define TC_AC_OC          8'h03
`define TC_BRAKE_OC       8'h04
`define TC_PSU            8'h05
`define TC_TUNE_FIRST     8'h0B
`define TC_TUNE_LAST      8'h12
`define TC_BRAKE_OL       8'h13
`define TC_OUT_OVERLOAD   8'h1A
`define TC_THERMAL_OHT    8'h1B
`define TC_AIN2_LOSS      8'h1C
`define TC_AIN3_LOSS      8'h1D
`define TC_SERIAL_LOSS    8'h1E
`define TC_PARAM_CORRUPT  8'h1F
`define TC_PHASE_LOSS     8'h20
`define TC_MOD_FIRST      8'h65
`define TC_MOD_MAINS      8'h65
`define TC_MOD_OVERTEMP   8'h66
`define TC_MOD_BRAKE_OC   8'h67
`define TC_MOD_AC_OC      8'h68
`define TC_MOD_PHASE      8'h6B
`define TC_MOD_DC_OC      8'h6D
`define TC_MOD_UNID       8'h6E
`define TC_MOD_LAST       8'h6E
`define TC_SLOT1_HF       8'hC8
`define TC_SLOT2_HF       8'hCD
`define TC_SLOT3_HF       8'hD2
`define HF_FATAL_LAST     8'h11
`define HF_LAST           8'h20

// timing
`define CLK_MHZ           250
`define RESET_DELAY_MS    1000
`define EXT_DELAY_MS      10000
`define OHT_STOP_MS       10000

// under-voltage trip / restart levels in volts
`define UV_TRIP_200       11'd175
`define UV_RESTART_200    11'd215
`define UV_TRIP_400       11'd330
`define UV_RESTART_400    11'd425
`define UV_TRIP_HI        11'd435
`define UV_RESTART_HI     11'd590

`define MODULES           4

`endif

// ==== src/drive_trip_manager.v ====
// Function
// - hardware faults 1-17 are fatal, never cleared, drive inactive, fault number shown.
// - under-voltage trip ignores user reset, clears itself when supply recovers.
// - hardware faults 18-32 and slot one-three hardware faults cannot be reset.
// - parameter corruption trip resets only after load-defaults code entered.
// - autotune trips reset after 1.0 s and only while drive not enabled.
// - AC, brake and module over-current trips reset only after 10.0 s.
// - overload and current-loss trips stop motor first when stop setting is 1 or 3.
// - phase loss stops the motor before tripping.
// - thermal over-heat stops first, trips anyway after 10 s.
// - all other trips reset after 1.0 s.
// - under-voltage trip and restart levels follow the voltage rating.
// - codes 101-110 are power module trips carrying a module number.
// - single module without parallel interface allows only three requested module trips, module zero; partial-loss trips 101 and 107 still occur.
// - parallel drives allow all module trips and log the source module.
// - partial mains loss gives module mains trip; total loss uses dc-link handling.
// - partial phase loss gives module phase trip; total loss uses ripple detection.
// - module mains and phase trips suppressed when partial-loss disable is one.
// - brake runs while drive disabled, inhibited on low-voltage supply.
// - brake disabled on brake over-current, supply, brake overload, overvoltage, even masked.
// - during under-voltage trip everything runs but enable is refused.
// - parameters reload only after supply shuts psu down and restarts it.
// - entering under-voltage saves parameters unless low-voltage supply selected.
// - power-up under-voltage trips without saving, yields to other power-up trips.
`timescale 1ns/100ps
`default_nettype none
`include "trip_regs.vh"

module drive_trip_manager #(
  parameter [31:0] RESET_DELAY_CYC = `RESET_DELAY_MS * `CLK_MHZ * 1000,
  parameter [31:0] EXT_DELAY_CYC   = `EXT_DELAY_MS * `CLK_MHZ * 1000,
  parameter [31:0] OHT_STOP_CYC    = `OHT_STOP_MS * `CLK_MHZ * 1000
) (
  input  wire        aclk,              // 250 MHz clock
  input  wire        aresetn,           // sync reset, active low
  input  wire [7:0]  s_axi_awaddr,      // write address
  input  wire        s_axi_awvalid,     // write address valid
  output wire        s_axi_awready,     // write address ready
  input  wire [31:0] s_axi_wdata,       // write data
  input  wire [3:0]  s_axi_wstrb,       // write strobes
  input  wire        s_axi_wvalid,      // write data valid
  output wire        s_axi_wready,      // write data ready
  output reg  [1:0]  s_axi_bresp,       // write response
  output reg         s_axi_bvalid,      // write response valid
  input  wire        s_axi_bready,      // write response ready
  input  wire [7:0]  s_axi_araddr,      // read address
  input  wire        s_axi_arvalid,     // read address valid
  output wire        s_axi_arready,     // read address ready
  output reg  [31:0] s_axi_rdata,       // read data
  output reg  [1:0]  s_axi_rresp,       // read response
  output reg         s_axi_rvalid,      // read data valid
  input  wire        s_axi_rready,      // read data ready
  input  wire        trip_req,          // trip event pulse
  input  wire [7:0]  trip_req_code,     // code of that trip
  input  wire [3:0]  trip_req_module,   // source module of that trip
  input  wire        hw_fault_req,      // hardware fault pulse
  input  wire [7:0]  hw_fault_num,      // hardware fault number 1-32
  input  wire [10:0] dc_bus_volts,      // dc bus voltage in volts
  input  wire        psu_shutdown,      // internal power supply is off
  input  wire        motor_stopped,     // motor at standstill
  input  wire        drive_enable_req,  // enable asked for
  input  wire [`MODULES-1:0] module_mains_loss, // per-module mains loss
  input  wire [`MODULES-1:0] module_phase_loss, // per-module phase loss
  output reg         drive_enable,      // drive allowed to run
  output reg         drive_inactive,    // fatal fault, drive dead
  output reg         stop_request,      // controlled stop before trip
  output reg         brake_enable,      // braking switch allowed
  output reg         dc_link_mains_loss_mode, // all modules lost mains
  output reg         dc_link_ripple_mode,     // all modules lost a phase
  output reg         save_params,       // power-down save pulse
  output reg         nv_reload,         // reload parameters pulse
  output reg  [7:0]  active_code,       // active trip code, 0 none
  output reg         active_is_hf,      // active code is a hardware fault
  output reg  [3:0]  active_module      // module shown with the trip
);

////////////////////////////////////////////////////////////////////////////////
  localparam [3:0] ST_RUN  = 4'b0001;
  localparam [3:0] ST_STOP = 4'b0010;
  localparam [3:0] ST_TRIP = 4'b0100;
  localparam [3:0] ST_DEAD = 4'b1000;

  reg [31:0] ctrl_r;
  reg        awfull_r;
  reg        wfull_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  reg [3:0]  state_r;
  reg [7:0]  pend_code_r;
  reg [3:0]  pend_mod_r;
  reg [31:0] tmr_r;
  reg        defaults_r;
  reg        brake_inh_r;
  reg        powerup_r;
  reg        psu_down_r;
  reg [`LOG_PTR_W-1:0] log_ptr_r;
  reg [11:0] log_mem [0:`LOG_DEPTH-1];

  wire [1:0] rating  = ctrl_r[`CTRL_RATING_LSB +: 2];
  wire [1:0] sbt_sel = ctrl_r[`CTRL_SBT_LSB +: 2];
  wire       pld     = ctrl_r[`CTRL_PLD_BIT];
  wire       lvs     = ctrl_r[`CTRL_LVS_BIT];
  wire       par     = ctrl_r[`CTRL_PAR_BIT];

////////////////////////////////////////////////////////////////////////////////
// register bus: address and data may arrive in either order
  wire do_write = awfull_r && wfull_r && !s_axi_bvalid;
  wire wr_ctrl  = do_write && (awaddr_r == `REG_CTRL);
  wire wr_cmd   = do_write && (awaddr_r == `REG_CMD);
  wire wr_ok    = wr_ctrl || wr_cmd;
  wire user_rst = wr_cmd && wstrb_r[0] && wdata_r[`CMD_RESET_BIT];
  wire dflt_set = wr_cmd && wstrb_r[0] && wdata_r[`CMD_DEFAULTS_BIT];

  assign s_axi_awready = !awfull_r;
  assign s_axi_wready  = !wfull_r;
  assign s_axi_arready = !s_axi_rvalid;

  integer b;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awfull_r     <= 1'b0;
      wfull_r      <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      ctrl_r       <= `CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && !awfull_r)
      begin
        awfull_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !wfull_r)
      begin
        wfull_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
        for (b = 0; b < 4; b = b + 1)
          if (wr_ctrl && wstrb_r[b])
            ctrl_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awfull_r     <= 1'b0;
        wfull_r      <= 1'b0;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// under-voltage levels
  reg [10:0] uv_trip_lvl;
  reg [10:0] uv_restart_lvl;
  always @*
  begin
    case (rating)
      2'h0:
      begin
        uv_trip_lvl    = `UV_TRIP_200;
        uv_restart_lvl = `UV_RESTART_200;
      end
      2'h1:
      begin
        uv_trip_lvl    = `UV_TRIP_400;
        uv_restart_lvl = `UV_RESTART_400;
      end
      default:
      begin
        uv_trip_lvl    = `UV_TRIP_HI;
        uv_restart_lvl = `UV_RESTART_HI;
      end
    endcase
  end
  wire uv_low     = dc_bus_volts < uv_trip_lvl;
  wire uv_restart = dc_bus_volts >= uv_restart_lvl;

////////////////////////////////////////////////////////////////////////////////
// partial module losses
  wire mains_any = |module_mains_loss;
  wire mains_all = &module_mains_loss;
  wire phase_any = |module_phase_loss;
  wire phase_all = &module_phase_loss;
  wire mod_mains_trip = mains_any && !mains_all && !pld;
  wire mod_phase_trip = phase_any && !phase_all && !pld;

  // module trips need the parallel interface, except three that any module raises
  wire req_is_mod = (trip_req_code >= `TC_MOD_FIRST) && (trip_req_code <= `TC_MOD_LAST);
  wire mod_always = (trip_req_code == `TC_MOD_DC_OC) || (trip_req_code == `TC_MOD_OVERTEMP)
                    || (trip_req_code == `TC_MOD_UNID);
  wire ext_ok     = trip_req && (!req_is_mod || par || mod_always);
  wire [3:0] ext_mod = (req_is_mod && par) ? trip_req_module : 4'h0;

  // these trips kill the brake even when another trip already holds
  wire brake_kill = ext_ok && ((trip_req_code == `TC_BRAKE_OC) || (trip_req_code == `TC_PSU)
                    || (trip_req_code == `TC_BRAKE_OL) || (trip_req_code == `TC_OV));

  // codes that stop the motor before the trip is entered
  wire low_prio = (trip_req_code == `TC_OUT_OVERLOAD) || (trip_req_code == `TC_AIN2_LOSS)
                  || (trip_req_code == `TC_AIN3_LOSS) || (trip_req_code == `TC_SERIAL_LOSS);
  wire stop_first = (low_prio && sbt_sel[0])
                    || (trip_req_code == `TC_PHASE_LOSS)
                    || (trip_req_code == `TC_THERMAL_OHT);

////////////////////////////////////////////////////////////////////////////////
// reset permission for the active trip
  reg reset_ok;
  always @*
  begin
    reset_ok = 1'b0;
    if (active_is_hf)
      reset_ok = 1'b0;
    else
      case (active_code)
        `TC_UV:
          reset_ok = 1'b0;
        `TC_SLOT1_HF, `TC_SLOT2_HF, `TC_SLOT3_HF:
          reset_ok = 1'b0;
        `TC_PARAM_CORRUPT:
          reset_ok = defaults_r;
        `TC_AC_OC, `TC_BRAKE_OC, `TC_MOD_AC_OC, `TC_MOD_BRAKE_OC, `TC_MOD_DC_OC:
          reset_ok = tmr_r >= EXT_DELAY_CYC;
        default:
          if (active_code >= `TC_TUNE_FIRST && active_code <= `TC_TUNE_LAST)
            reset_ok = (tmr_r >= RESET_DELAY_CYC) && !drive_enable_req;
          else
            reset_ok = tmr_r >= RESET_DELAY_CYC;
      endcase
  end

////////////////////////////////////////////////////////////////////////////////
// trip sequencer
  reg [3:0]  state_nxt;
  reg [7:0]  code_nxt;
  reg [3:0]  mod_nxt;
  reg        hf_nxt;
  reg        enter;
  reg        save_nxt;
  always @*
  begin
    state_nxt = state_r;
    code_nxt  = active_code;
    mod_nxt   = active_module;
    hf_nxt    = active_is_hf;
    enter     = 1'b0;
    save_nxt  = 1'b0;
    case (state_r)
      ST_RUN, ST_STOP:
      begin
        if (hw_fault_req && hw_fault_num != 8'h00 && hw_fault_num <= `HF_LAST)
        begin
          state_nxt = (hw_fault_num <= `HF_FATAL_LAST) ? ST_DEAD : ST_TRIP;
          code_nxt  = hw_fault_num;
          mod_nxt   = 4'h0;
          hf_nxt    = 1'b1;
          enter     = 1'b1;
        end
        else if (ext_ok && !(stop_first && state_r == ST_RUN))
        begin
          state_nxt = ST_TRIP;
          code_nxt  = trip_req_code;
          mod_nxt   = ext_mod;
          hf_nxt    = 1'b0;
          enter     = 1'b1;
        end
        else if (ext_ok)
        begin
          state_nxt = ST_STOP;
        end
        else if (state_r == ST_STOP && (motor_stopped
                 || (pend_code_r == `TC_THERMAL_OHT && tmr_r >= OHT_STOP_CYC)))
        begin
          state_nxt = ST_TRIP;
          code_nxt  = pend_code_r;
          mod_nxt   = pend_mod_r;
          hf_nxt    = 1'b0;
          enter     = 1'b1;
        end
        else if (mod_mains_trip || mod_phase_trip)
        begin
          state_nxt = ST_TRIP;
          code_nxt  = mod_mains_trip ? `TC_MOD_MAINS : `TC_MOD_PHASE;
          mod_nxt   = 4'h0;
          hf_nxt    = 1'b0;
          enter     = 1'b1;
        end
        else if (uv_low || (powerup_r && !uv_restart))
        begin
          state_nxt = ST_TRIP;
          code_nxt  = `TC_UV;
          mod_nxt   = 4'h0;
          hf_nxt    = 1'b0;
          enter     = 1'b1;
          save_nxt  = !lvs && !powerup_r;
        end
      end
      ST_TRIP:
      begin
        if (hw_fault_req && hw_fault_num != 8'h00 && hw_fault_num <= `HF_FATAL_LAST)
        begin
          state_nxt = ST_DEAD;
          code_nxt  = hw_fault_num;
          mod_nxt   = 4'h0;
          hf_nxt    = 1'b1;
          enter     = 1'b1;
        end
        else if ((active_code == `TC_UV && !active_is_hf && uv_restart)
                 || (user_rst && reset_ok))
        begin
          state_nxt = ST_RUN;
          code_nxt  = `TC_NONE;
          mod_nxt   = 4'h0;
          hf_nxt    = 1'b0;
        end
      end
      ST_DEAD:
        state_nxt = ST_DEAD;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r       <= ST_RUN;
      active_code   <= `TC_NONE;
      active_module <= 4'h0;
      active_is_hf  <= 1'b0;
      pend_code_r   <= `TC_NONE;
      pend_mod_r    <= 4'h0;
      tmr_r         <= 32'h0000_0000;
      save_params   <= 1'b0;
      log_ptr_r     <= {`LOG_PTR_W{1'b0}};
    end
    else
    begin
      state_r       <= state_nxt;
      active_code   <= code_nxt;
      active_module <= mod_nxt;
      active_is_hf  <= hf_nxt;
      save_params   <= save_nxt;
      if (state_r == ST_RUN && state_nxt == ST_STOP)
      begin
        pend_code_r <= trip_req_code;
        pend_mod_r  <= ext_mod;
      end
      // one timer serves the stop timeout and the reset delays
      if (enter || (state_r == ST_RUN && state_nxt == ST_STOP))
        tmr_r <= 32'h0000_0000;
      else if (tmr_r != 32'hFFFF_FFFF)
        tmr_r <= tmr_r + 32'h0000_0001;
      if (enter)
        log_ptr_r <= log_ptr_r + {{(`LOG_PTR_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge aclk)
  begin
    if (enter)
      log_mem[log_ptr_r] <= {mod_nxt, code_nxt};
  end

////////////////////////////////////////////////////////////////////////////////
// side flags and outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      defaults_r  <= 1'b0;
      brake_inh_r <= 1'b0;
      powerup_r   <= 1'b1;
      psu_down_r  <= 1'b0;
      nv_reload   <= 1'b0;
    end
    else
    begin
      // set wins over the clear
      if (dflt_set)
        defaults_r <= 1'b1;
      else if (state_r == ST_TRIP && state_nxt == ST_RUN)
        defaults_r <= 1'b0;
      if (brake_kill)
        brake_inh_r <= 1'b1;
      else if (state_r == ST_TRIP && state_nxt == ST_RUN)
        brake_inh_r <= 1'b0;
      if (uv_restart)
        powerup_r <= 1'b0;
      if (psu_shutdown)
        psu_down_r <= 1'b1;
      else if (psu_down_r)
        psu_down_r <= 1'b0;
      nv_reload <= psu_down_r && !psu_shutdown;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drive_enable            <= 1'b0;
      drive_inactive          <= 1'b0;
      stop_request            <= 1'b0;
      brake_enable            <= 1'b0;
      dc_link_mains_loss_mode <= 1'b0;
      dc_link_ripple_mode     <= 1'b0;
    end
    else
    begin
      drive_enable            <= drive_enable_req && (state_nxt == ST_RUN);
      drive_inactive          <= state_nxt == ST_DEAD;
      stop_request            <= state_nxt == ST_STOP;
      brake_enable            <= !lvs && !brake_inh_r && !brake_kill
                                 && state_nxt != ST_DEAD;
      dc_link_mains_loss_mode <= mains_all;
      dc_link_ripple_mode     <= phase_all;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// register reads
  wire [31:0] status = {10'h000, reset_ok && state_r == ST_TRIP, defaults_r,
                        active_module, 2'b00, active_is_hf,
                        state_r == ST_TRIP && active_code == `TC_UV && !active_is_hf,
                        brake_enable, state_r == ST_STOP, state_r == ST_DEAD,
                        state_r == ST_TRIP || state_r == ST_DEAD, active_code};

  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire log_hit  = (ra >= `REG_LOG_BASE) && (ra < `REG_LOG_BASE + 4 * `LOG_DEPTH);
  wire [7:0] log_off = ra - `REG_LOG_BASE;
  wire [`LOG_PTR_W-1:0] log_idx = log_off[`LOG_PTR_W+1:2];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      if (ra == `REG_CTRL)
        s_axi_rdata <= ctrl_r;
      else if (ra == `REG_CMD)
        s_axi_rdata <= 32'h0000_0000;
      else if (ra == `REG_STATUS)
        s_axi_rdata <= status;
      else if (ra == `REG_LOG_PTR)
        s_axi_rdata <= {{(32-`LOG_PTR_W){1'b0}}, log_ptr_r};
      else if (log_hit)
        s_axi_rdata <= {20'h00000, log_mem[log_idx]};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'h2;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule
`default_nettype wire

// ==== sim/power_modules.sv ====
`timescale 1ns/100ps
`default_nettype none
// parallel power modules: each input stage reports its own loss, one edge late
module power_modules (
  input  wire logic [3:0] mains_cmd,  // modules told to lose mains
  input  wire logic [3:0] phase_cmd,  // modules told to lose a phase
  input  wire logic       aclk,       // clock
  output var  logic [3:0] mains_loss, // per-module mains loss
  output var  logic [3:0] phase_loss  // per-module phase loss
);
  always @(posedge aclk)
  begin
    mains_loss <= mains_cmd;
    phase_loss <= phase_cmd;
  end
endmodule
`default_nettype wire

// ==== sim/drive_trip_manager_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module trip_checker (
  input wire aclk, aresetn, trip_req, hw_fault_req, psu_shutdown, // inputs
  input wire [7:0] trip_req_code, hw_fault_num, active_code,        // codes
  input wire [3:0] module_mains_loss, module_phase_loss,            // module flags
  input wire drive_enable, drive_inactive, brake_enable, save_params, // outputs
  input wire nv_reload, active_is_hf, stop_request,                   // outputs
  input wire dc_link_mains_loss_mode, dc_link_ripple_mode             // outputs
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_fatal_hold: assert property (drive_inactive |=> drive_inactive)
    else $error("dead state left");
  a_dead_idle: assert property (drive_inactive |-> !drive_enable)
    else $error("dead drive enabled");
  a_hf_entry: assert property (hw_fault_req && hw_fault_num inside {[1:17]} && !drive_inactive
    |=> drive_inactive && active_is_hf && active_code == $past(hw_fault_num))
    else $error("fatal fault not taken");
  a_hf_range: assert property (active_is_hf |-> active_code inside {[8'h01:8'h20]})
    else $error("fault number out of range");
  a_trip_refuse: assert property (active_code != 8'h00 |-> !drive_enable)
    else $error("enabled while tripped");
  a_brake_kill: assert property (trip_req && trip_req_code inside {8'h02, 8'h04, 8'h05, 8'h13}
    |-> ##[1:2] !brake_enable)
    else $error("brake not killed");
  a_save_pulse: assert property (save_params |=> !save_params)
    else $error("save not a pulse");
  a_reload_src: assert property (nv_reload |-> $past(psu_shutdown) || $past(psu_shutdown, 2)
    || $past(psu_shutdown, 3))
    else $error("reload without supply restart");
  a_mains_all: assert property (&module_mains_loss |=> dc_link_mains_loss_mode)
    else $error("total mains loss missed");
  a_ripple_all: assert property (&module_phase_loss |=> dc_link_ripple_mode)
    else $error("total phase loss missed");
  c_dead: cover property (drive_inactive);
  c_save: cover property (save_params);
  c_stop: cover property (stop_request);
  c_reload: cover property (nv_reload);
endmodule
bind drive_trip_manager trip_checker u_chk (.*);
`default_nettype wire

// ==== sim/drive_trip_manager_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module drive_trip_manager_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, trip_req;
  logic hw_fault_req, psu_shutdown, motor_stopped, drive_enable_req, drive_enable, nv_reload;
  logic drive_inactive, stop_request, brake_enable, dc_link_mains_loss_mode, dc_link_ripple_mode;
  logic save_params, active_is_hf, saw_save, saw_reload;
  logic [7:0] s_axi_awaddr, s_axi_araddr, trip_req_code, hw_fault_num, active_code;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [3:0] trip_req_module, active_module, module_mains_loss, module_phase_loss, lm, lp;
  logic [10:0] dc_bus_volts;
  logic [10:0] tp [4] = '{11'd175, 11'd330, 11'd435, 11'd435};
  logic [10:0] rs [4] = '{11'd215, 11'd425, 11'd590, 11'd590};
  int err_count, tests_run;
  // short delays so the timed resets stay inside the run
  drive_trip_manager #(.RESET_DELAY_CYC(20), .EXT_DELAY_CYC(50), .OHT_STOP_CYC(40)) u_dut (
    .s_axi_wstrb(4'hF), .*);
  power_modules u_mod (.aclk, .mains_cmd(lm), .phase_cmd(lp), .mains_loss(module_mains_loss),
    .phase_loss(module_phase_loss));
  //////////////////////////////////////////
  initial
  begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    if (save_params) saw_save <= 1;
    if (nv_reload) saw_reload <= 1;
  end
  task summarize;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  task pulse(input logic [7:0] c, input logic [3:0] m);
    trip_req_code <= c;
    trip_req_module <= m;
    trip_req <= 1;
    @(posedge aclk);
    trip_req <= 0;
    @(posedge aclk);
  endtask
  task w(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task rf(input int n);
    w(n);
    wr(8'h04, 32'h1);
  endtask
  task clr(input int n);
    rf(n);
    chk(active_code, 8'h00);
  endtask
  task tr(input logic [7:0] c, input int n);
    pulse(c, 4'h0);
    chk(active_code, c);
    wr(8'h04, 32'h1);
    chk(active_code, c);
    clr(n);
  endtask
  task sf(input logic [7:0] c);
    pulse(c, 4'h0);
    w(2);
    chk(stop_request, 1'b1);
    chk(active_code, 8'h00);
    motor_stopped <= 1;
    w(3);
    chk(active_code, c);
    motor_stopped <= 0;
    clr(25);
  endtask
  //////////////////////////////////////////
  task t_uv;
    w(3);
    chk(active_code, 8'h01);
    chk(saw_save, 1'b0);
    chk(drive_enable, 1'b0);
    wr(8'h04, 32'h1);
    chk(active_code, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, i);
      dc_bus_volts <= rs[i] - 11'd1;
      w(3);
      chk(active_code, 8'h01);
      dc_bus_volts <= rs[i];
      w(3);
      chk(active_code, 8'h00);
      dc_bus_volts <= tp[i];
      w(3);
      chk(active_code, 8'h00);
      dc_bus_volts <= tp[i] - 11'd1;
      w(3);
      chk(active_code, 8'h01);
    end
    chk(saw_save, 1'b1);
    dc_bus_volts <= 11'd700;
    w(3);
    chk(drive_enable, 1'b1);
    drive_enable_req <= 0;
  endtask
  task t_trips;
    wr(8'h00, 32'h0);
    rd(8'h10);
    chk({d, r}, 34'h2);
    tr(8'h03, 55);
    tr(8'h0B, 25);
    tr(8'h06, 25);
    tr(8'h04, 55);
    chk(brake_enable, 1'b1);
    pulse(8'h1F, 4'h0);
    rf(25);
    chk(active_code, 8'h1F);
    wr(8'h04, 32'h2);
    clr(1);
    wr(8'h00, 32'h20);
    chk(brake_enable, 1'b0);
    wr(8'h00, 32'h04);
    sf(8'h1A);
    sf(8'h20);
    wr(8'h00, 32'h0C);
    sf(8'h1D);
    pulse(8'h1B, 4'h0);
    w(30);
    chk(active_code, 8'h00);
    w(15);
    chk(active_code, 8'h1B);
    clr(25);
  endtask
  task t_modules;
    wr(8'h00, 32'h40);
    pulse(8'h6E, 4'h3);
    chk(active_module, 4'h3);
    rd(8'h0C);
    rd(8'h20 + {d[2:0] - 3'd1, 2'b00});
    chk(d, 32'h36E);
    clr(25);
    lm <= 4'h1;
    w(4);
    chk(active_code, 8'h65);
    lm <= 4'hF;
    clr(25);
    chk(dc_link_mains_loss_mode, 1'b1);
    lm <= 4'h0;
    lp <= 4'h3;
    w(4);
    chk(active_code, 8'h6B);
    lp <= 4'hF;
    clr(25);
    chk(dc_link_ripple_mode, 1'b1);
    lp <= 4'h0;
    wr(8'h00, 32'h50);
    lm <= 4'h3;
    w(4);
    chk(active_code, 8'h00);
    lm <= 4'h0;
    wr(8'h00, 32'h0);
    pulse(8'h68, 4'h3);
    chk(active_code, 8'h00);
    pulse(8'h6E, 4'h3);
    chk(active_module, 4'h0);
    clr(25);
  endtask
  task t_fatal;
    chk(saw_reload, 1'b0);
    psu_shutdown <= 1;
    w(3);
    psu_shutdown <= 0;
    w(3);
    chk(saw_reload, 1'b1);
    hw_fault_num <= 8'd5;
    hw_fault_req <= 1;
    @(posedge aclk);
    hw_fault_req <= 0;
    @(posedge aclk);
    chk(drive_inactive, 1'b1);
    rf(25);
    chk(active_code, 8'h05);
  endtask
  //////////////////////////////////////////
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {trip_req, hw_fault_req, psu_shutdown, motor_stopped, saw_save, saw_reload} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, trip_req_code, trip_req_module, hw_fault_num} = 0;
    {lm, lp, err_count, tests_run} = 0;
    drive_enable_req = 1;
    dc_bus_volts = 11'd100;
    w(10);
    aresetn <= 1;
    t_uv;
    t_trips;
    t_modules;
    t_fatal;
    summarize;
  end
  initial
  begin
    w(20000);
    err_count++;
    summarize;
  end
endmodule
`default_nettype wire
